// ===== src/osr_pkg.sv
package osr_pkg;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_OTP_READ = 8'h77; // Security-region read.
  localparam logic [7:0] CMD_STAT_READ = 8'h05; // Status stream read.
  localparam logic [7:0] CMD_STAT_WRITE = 8'h01; // Status byte 1 write.
  localparam logic [7:0] CMD_WR_ENABLE = 8'h06; // Sets the write latch.
  localparam logic [7:0] CMD_WR_DISABLE = 8'h04; // Clears the write latch.

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam logic [1:0] ADDR_BYTES = 2'h3; // Address bytes after 77h.
  localparam logic [1:0] DUMMY_BYTES = 2'h2; // Dummy bytes before data.
  localparam int OTP_DEPTH = 128; // Security-region size in bytes.
  localparam int OTP_AW = 7; // Security-region address width.
  localparam logic [2:0] BIT_LAST = 3'h7; // Last bit of a byte.

  // ----------------------------------------------------------------
  // Status byte 1 and byte 2 field positions
  // ----------------------------------------------------------------
  localparam int SB1_LOCK = 7; // Protection lock.
  localparam int SB1_FAIL = 5; // Program or erase failure.
  localparam int SB1_PIN = 4; // Mirror of the protect pin.
  localparam int SB1_PROT = 2; // Whole-array protect.
  localparam int SB1_WEL = 1; // Write latch.
  localparam int SB_BUSY = 0; // Busy, in both bytes.
  localparam int SB2_SOFT_RESET_ALLOW = 4; // Soft reset allow.

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic RST_LOCK = 1'b0; // Lock clear at power-up.
  localparam logic RST_PROT = 1'b0; // Array starts unprotected.
  localparam logic RST_FAIL = 1'b0; // No failure recorded.
  localparam logic RST_WEL = 1'b0; // Not write enabled.
  localparam logic RST_SOFT_RESET_ALLOW = 1'b0; // Soft reset disabled.

  // ----------------------------------------------------------------
  // Command state machine
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CMD,
    ST_ADDR,
    ST_DUMMY,
    ST_OTP_OUT,
    ST_STAT_OUT,
    ST_WSR_DATA,
    ST_TAIL
  } osr_state_t;

endpackage : osr_pkg

// ===== src/osr_otp_mem.sv
`timescale 1ns/100ps

// ------------------------------------------------------------------
// Security-region storage with a registered read port
// ------------------------------------------------------------------
module osr_otp_mem
  import osr_pkg::*;
#(
  parameter int DEPTH = OTP_DEPTH,
  parameter int AW = OTP_AW
) (
  // Clock.
  input wire logic mclk,
  // Contents load port, used by the factory and user loaders.
  input wire logic load_we,
  input wire logic [AW-1:0] load_addr,
  input wire logic [7:0] load_data,
  // Read port.
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data
);

  // The array holds no reset so that it maps onto plain RAM.
  logic [7:0] mem_q [DEPTH];

  // Contents are written only through the load port.
  always_ff @(posedge mclk) begin
    if (load_we) begin
      mem_q[load_addr] <= load_data;
    end
  end

  // One cycle of read latency; the caller waits eight link edges anyway.
  always_ff @(posedge mclk) begin
    rd_data <= mem_q[rd_addr];
  end

endmodule : osr_otp_mem

// ===== src/osr_top.sv
`timescale 1ns/100ps

module osr_top
  import osr_pkg::*;
(
  // Clock and synchronous reset.
  input wire logic mclk,
  input wire logic reset_n,
  // Serial link pins from the host.
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic si,
  // Serial output pin, driven only while enable is high.
  output logic so_data,
  output logic so_oe,
  // Write protect pin, active low.
  input wire logic wp_n,
  // Array engine interface.
  input wire logic array_busy,
  input wire logic op_req,
  output logic op_grant,
  input wire logic op_done,
  input wire logic op_fail,
  // Security-region contents load port.
  input wire logic load_we,
  input wire logic [OTP_AW-1:0] load_addr,
  input wire logic [7:0] load_data,
  // Protection state for the array engine.
  output logic array_protect
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pin_m_q; // First stage, read only by the second stage.
  logic [3:0] pin_s_q; // Second stage, safe to use.
  logic sclk_d_q; // Delayed clock for edge detection.
  logic cs_d_q; // Delayed chip select for release detection.
  logic cs_s;
  logic sclk_s;
  logic si_s;
  logic wp_n_s;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_release;

  // Two flops on every pin; the link clock is just another pin here.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pin_m_q <= 4'hF;
      pin_s_q <= 4'hF;
    end else begin
      pin_m_q <= {wp_n, si, sclk, cs_n};
      pin_s_q <= pin_m_q;
    end
  end

  assign cs_s = pin_s_q[0];
  assign sclk_s = pin_s_q[1];
  assign si_s = pin_s_q[2];
  assign wp_n_s = pin_s_q[3];

  // Edge history is kept from the second stage only.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      sclk_d_q <= 1'b0;
      cs_d_q <= 1'b1;
    end else begin
      sclk_d_q <= sclk_s;
      cs_d_q <= cs_s;
    end
  end

  // Edges count only inside a frame, so idle clock noise is ignored.
  assign sclk_rise = !cs_s && sclk_s && !sclk_d_q;
  assign sclk_fall = !cs_s && !sclk_s && sclk_d_q;
  assign cs_release = cs_s && !cs_d_q;

  // ----------------------------------------------------------------
  // Status bits
  // ----------------------------------------------------------------
  logic lock_q; // Protection lock.
  logic prot_q; // Whole-array protect.
  logic fail_q; // Last operation failed.
  logic wel_q; // Write latch.
  logic soft_reset_allow_q; // Soft reset allow; no writer in this block.

  // Builds either status byte from the live bits.
  function automatic logic [7:0] status_byte(input logic second);
    logic [7:0] b;
    b = 8'h00;
    if (second) begin
      b[SB2_SOFT_RESET_ALLOW] = soft_reset_allow_q;
      b[SB_BUSY] = array_busy;
    end else begin
      b[SB1_LOCK] = lock_q;
      b[SB1_FAIL] = fail_q;
      b[SB1_PIN] = wp_n_s;
      b[SB1_PROT] = prot_q;
      b[SB1_WEL] = wel_q;
      b[SB_BUSY] = array_busy;
    end
    return b;
  endfunction : status_byte

  // ----------------------------------------------------------------
  // Command receiver
  // ----------------------------------------------------------------
  osr_state_t state_q;
  logic [2:0] bit_cnt_q; // Rising edges within the current byte.
  logic [1:0] byte_cnt_q; // Bytes within address or dummy phase.
  logic [7:0] rx_q; // Input shift register.
  logic [7:0] cmd_q; // Opcode of the current frame.
  logic [7:0] wsr_byte_q; // Data byte of a status write.
  logic wsr_full_q; // Status write byte complete.
  logic [OTP_AW-1:0] otp_addr_q; // Next security byte to send.
  logic [7:0] rx_byte;
  logic byte_done;

  assign rx_byte = {rx_q[6:0], si_s};
  assign byte_done = sclk_rise && (bit_cnt_q == BIT_LAST);

  // Input bits are taken on rising link edges, MSB first.
  always_ff @(posedge mclk) begin
    if (!reset_n || cs_s) begin
      bit_cnt_q <= 3'h0;
      rx_q <= 8'h00;
    end else if (sclk_rise) begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      rx_q <= rx_byte;
    end
  end

  // Frame sequencing; a released select ends any frame at once.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      byte_cnt_q <= 2'h0;
      cmd_q <= 8'h00;
    end else if (cs_s) begin
      state_q <= ST_IDLE;
      byte_cnt_q <= 2'h0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          state_q <= ST_CMD;
        end
        ST_CMD: begin
          if (byte_done) begin
            cmd_q <= rx_byte;
            byte_cnt_q <= 2'h0;
            if (rx_byte == CMD_OTP_READ) begin
              state_q <= ST_ADDR;
            end else if (rx_byte == CMD_STAT_READ) begin
              // Accepted whether or not the array is busy.
              state_q <= ST_STAT_OUT;
            end else if (rx_byte == CMD_STAT_WRITE) begin
              state_q <= ST_WSR_DATA;
            end else begin
              state_q <= ST_TAIL;
            end
          end
        end
        ST_ADDR: begin
          if (byte_done) begin
            if (byte_cnt_q == ADDR_BYTES - 2'h1) begin
              byte_cnt_q <= 2'h0;
              state_q <= ST_DUMMY;
            end else begin
              byte_cnt_q <= byte_cnt_q + 2'h1;
            end
          end
        end
        ST_DUMMY: begin
          if (byte_done) begin
            if (byte_cnt_q == DUMMY_BYTES - 2'h1) begin
              state_q <= ST_OTP_OUT;
            end else begin
              byte_cnt_q <= byte_cnt_q + 2'h1;
            end
          end
        end
        ST_WSR_DATA: begin
          if (byte_done) begin
            state_q <= ST_TAIL; // Later bytes are ignored.
          end
        end
        default: begin
          // Output states and the tail hold until select is released.
          state_q <= state_q;
        end
      endcase
    end
  end

  // Status write data; only the first byte after the opcode counts.
  always_ff @(posedge mclk) begin
    if (!reset_n || cs_s) begin
      wsr_byte_q <= 8'h00;
      wsr_full_q <= 1'b0;
    end else if (state_q == ST_WSR_DATA && byte_done) begin
      wsr_byte_q <= rx_byte;
      wsr_full_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Output shifter
  // ----------------------------------------------------------------
  logic [2:0] out_cnt_q; // Falling edges within the output byte.
  logic stat_sel_q; // Which status byte is loaded next.
  logic [7:0] tx_q; // Output shift register.
  logic oe_q; // Output driven.
  logic [7:0] otp_rdata;
  logic out_state;
  logic load_byte;

  assign out_state = (state_q == ST_OTP_OUT) || (state_q == ST_STAT_OUT);
  assign load_byte = out_state && sclk_fall && (out_cnt_q == 3'h0);

  // Security-region address: start from low seven address bits.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      otp_addr_q <= '0;
    end else if (state_q == ST_ADDR && byte_done) begin
      otp_addr_q <= rx_byte[OTP_AW-1:0];
    end else if (state_q == ST_OTP_OUT && load_byte) begin
      // Seven-bit counter rolls 7Fh over to 00h with no gap.
      otp_addr_q <= otp_addr_q + 7'h01;
    end
  end

  // Data changes on falling link edges so the host samples it stably.
  always_ff @(posedge mclk) begin
    if (!reset_n || cs_s || !out_state) begin
      out_cnt_q <= 3'h0;
      stat_sel_q <= 1'b0;
      tx_q <= 8'h00;
    end else if (load_byte) begin
      out_cnt_q <= 3'h1;
      if (state_q == ST_OTP_OUT) begin
        tx_q <= otp_rdata;
      end else begin
        // Sampled at each byte start, never a frame-start snapshot.
        tx_q <= status_byte(stat_sel_q);
        stat_sel_q <= !stat_sel_q;
      end
    end else if (sclk_fall) begin
      out_cnt_q <= out_cnt_q + 3'h1;
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  // Output enable rises with the first output bit, falls with select.
  always_ff @(posedge mclk) begin
    if (!reset_n || cs_s || !out_state) begin
      oe_q <= 1'b0;
    end else if (load_byte) begin
      oe_q <= 1'b1;
    end
  end

  assign so_oe = oe_q && !cs_s;
  assign so_data = tx_q[7];

  osr_otp_mem #(
    .DEPTH(OTP_DEPTH),
    .AW(OTP_AW)
  ) u_mem (
    .mclk(mclk),
    .load_we(load_we),
    .load_addr(load_addr),
    .load_data(load_data),
    .rd_addr(otp_addr_q),
    .rd_data(otp_rdata)
  );

  // ----------------------------------------------------------------
  // Protection and write latch
  // ----------------------------------------------------------------
  logic frame_end_ok; // Released on a byte boundary after a full opcode.
  logic wsr_end; // A status write opcode frame has ended.
  logic wsr_apply;
  logic new_lock;
  logic new_prot;
  logic lock_refused;
  logic wel_set;
  logic wel_clr;

  assign frame_end_ok = cs_release && state_q == ST_TAIL && bit_cnt_q == 3'h0;
  assign wsr_end = cs_release && (cmd_q == CMD_STAT_WRITE)
                   && (state_q == ST_WSR_DATA || state_q == ST_TAIL);
  assign new_lock = wsr_byte_q[SB1_LOCK];
  assign new_prot = wsr_byte_q[SB1_PROT];
  // Clearing the lock while the pin is asserted voids the whole write.
  assign lock_refused = lock_q && !new_lock && !wp_n_s;
  assign wsr_apply = wsr_end && wsr_full_q && bit_cnt_q == 3'h0
                     && wel_q && !lock_refused;

  // Only lock and protect move, and only through a status write.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      lock_q <= RST_LOCK;
      prot_q <= RST_PROT;
    end else if (wsr_apply) begin
      lock_q <= new_lock;
      // Lock plus asserted pin freezes protect; lock clear leaves it free.
      if (!(lock_q && !wp_n_s)) begin
        prot_q <= new_prot;
      end
    end
  end

  // Program and erase are refused while protected, unlatched or busy.
  assign op_grant = op_req && wel_q && !prot_q && !array_busy;
  assign array_protect = prot_q;

  // Failure flag follows each completed operation; aborts leave it.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      fail_q <= RST_FAIL;
    end else if (op_done) begin
      fail_q <= op_fail;
    end
  end

  assign wel_set = frame_end_ok && cmd_q == CMD_WR_ENABLE;
  assign wel_clr = (frame_end_ok && cmd_q == CMD_WR_DISABLE) || wsr_end
                   || op_done || (op_req && !op_grant);

  // A set landing with a clear wins so a new enable is not lost.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wel_q <= RST_WEL;
    end else if (wel_set) begin
      wel_q <= 1'b1;
    end else if (wel_clr) begin
      wel_q <= 1'b0;
    end
  end

  // Soft reset allow has no writer here and keeps its default.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      soft_reset_allow_q <= RST_SOFT_RESET_ALLOW;
    end else begin
      soft_reset_allow_q <= soft_reset_allow_q;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_NO_DATA_EARLY: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (state_q == ST_ADDR || state_q == ST_DUMMY) |-> !so_oe)
    else $error("output driven before dummy bytes done");

  AST_OTP_CS_END: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (state_q == ST_OTP_OUT && cs_s) |-> !so_oe ##1 state_q == ST_IDLE)
    else $error("security read not ended by select release");

  AST_STAT_CS_END: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (state_q == ST_STAT_OUT && cs_s) |-> !so_oe ##1 !oe_q)
    else $error("status read not ended by select release");

  AST_OTP_WRAP: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (state_q == ST_OTP_OUT && load_byte && otp_addr_q == 7'h7F)
    |=> otp_addr_q == 7'h00)
    else $error("security address did not wrap to zero");

  AST_STAT_ALTERNATE: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (state_q == ST_STAT_OUT && load_byte && !stat_sel_q)
    |=> stat_sel_q && tx_q == {$past(lock_q), 1'b0, $past(fail_q),
      $past(wp_n_s), 1'b0, $past(prot_q), $past(wel_q), $past(array_busy)})
    else $error("status byte 1 not loaded first");

  AST_PROT_FROZEN: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (lock_q && !wp_n_s) |=> $stable(prot_q))
    else $error("protect bit changed while locked");

  AST_LOCK_CLEAR_PIN: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (lock_q && wsr_apply) ##1 !lock_q |-> $past(wp_n_s))
    else $error("lock cleared with protect pin asserted");

  AST_REFUSE_PROT: assert property (
    @(posedge mclk) disable iff (!reset_n)
    prot_q |-> !op_grant)
    else $error("operation granted on protected array");

  AST_FAIL_RESULT: assert property (
    @(posedge mclk) disable iff (!reset_n)
    op_done |=> fail_q == $past(op_fail))
    else $error("failure flag not updated from result");

  AST_ABORT_KEEPS_FAIL: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (op_req && !op_grant && !op_done) |=> $stable(fail_q))
    else $error("failure flag moved on an abort");

  AST_WEL_CLEARS: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (op_done && !wel_set) |=> !wel_q)
    else $error("write latch not cleared after operation");

endmodule : osr_top

// ===== sim/osr_spi_host.sv
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Serial host model, mode 0: the clock rests low outside frames.
// ----------------------------------------------------------------
module osr_spi_host (
  // Clock that paces the host.
  input wire logic mclk,
  // Serial pins towards the device.
  output logic cs_n,
  output logic sclk,
  output logic si,
  input wire logic so_data,
  input wire logic so_oe
);
  // Half link period in mclk cycles; 4 gives 200 ns, larger is slower.
  int half = 4;

  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
  end

  // Selects the device and leaves setup time before the first edge.
  task automatic frame_begin();
    @(negedge mclk) cs_n = 1'b0;
    repeat (4) @(negedge mclk);
  endtask : frame_begin

  // Releases the device; the input line shows the inverse of its last
  // value, so a device that still samples it reads something wrong.
  task automatic frame_end();
    @(negedge mclk) cs_n = 1'b1;
    si = ~si;
    repeat (6) @(negedge mclk);
  endtask : frame_end

  // Shifts n bits MSB first; data is read just before each fall.
  task automatic xfer(input int n, input logic [7:0] tx,
                      output logic [7:0] rx, output logic oe);
    rx = 8'h00;
    oe = 1'b0;
    for (int b = 7; b > 7 - n; b--) begin
      @(negedge mclk) si = tx[b];
      repeat (half - 1) @(negedge mclk);
      sclk = 1'b1;
      repeat (half) @(negedge mclk);
      // An undriven output line reads as the inverse of its last level.
      rx = {rx[6:0], so_oe ? so_data : !so_data};
      oe = oe | so_oe;
      sclk = 1'b0;
    end
  endtask : xfer
endmodule : osr_spi_host

// ===== sim/test_otp_and_status_read.sv
`timescale 1ns/100ps

module test_otp_and_status_read;
  import osr_pkg::*;
  // Design inputs and outputs.
  logic mclk, reset_n, wp_n, array_busy, op_req, op_done, op_fail, load_we;
  logic [OTP_AW-1:0] load_addr;
  logic [7:0] load_data;
  logic cs_n, sclk, si, so_data, so_oe, op_grant, array_protect;
  // Expected status state, kept by the bench itself.
  logic m_lock, m_prot, m_fail, m_wel;
  logic [7:0] mem [0:OTP_DEPTH-1];
  logic [7:0] r, t;
  logic oe;
  int bad_count, n_tests, i;

  osr_top osr_top_inst (.mclk(mclk), .reset_n(reset_n), .cs_n(cs_n),
    .sclk(sclk), .si(si), .so_data(so_data), .so_oe(so_oe), .wp_n(wp_n),
    .array_busy(array_busy), .op_req(op_req), .op_grant(op_grant),
    .op_done(op_done), .op_fail(op_fail), .load_we(load_we),
    .load_addr(load_addr), .load_data(load_data),
    .array_protect(array_protect));
  osr_spi_host osr_spi_host_inst (.mclk(mclk), .cs_n(cs_n), .sclk(sclk),
    .si(si), .so_data(so_data), .so_oe(so_oe));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] exp_b1();
    return {m_lock, 1'b0, m_fail, wp_n, 1'b0, m_prot, m_wel, array_busy};
  endfunction : exp_b1

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  // One whole command frame with an optional data byte.
  task automatic cmd(input logic [7:0] c, input int nd, input logic [7:0] d);
    osr_spi_host_inst.frame_begin();
    osr_spi_host_inst.xfer(8, c, r, oe);
    if (nd > 0) osr_spi_host_inst.xfer(8, d, r, oe);
    osr_spi_host_inst.frame_end();
  endtask : cmd

  // Status stream; each byte's expectation is taken as it starts.
  // The frame is cut three bits into a byte to test the release.
  task automatic stat_chk(input int reps);
    osr_spi_host_inst.frame_begin();
    osr_spi_host_inst.xfer(8, CMD_STAT_READ, r, oe);
    for (int j = 0; j < reps; j++) begin
      t = exp_b1();
      osr_spi_host_inst.xfer(8, 8'h00, r, oe);
      check(r, t);
      t = {7'h00, array_busy};
      osr_spi_host_inst.xfer(8, 8'h00, r, oe);
      check(r, t);
    end
    osr_spi_host_inst.xfer(3, 8'h00, r, oe);
    osr_spi_host_inst.frame_end();
    check({7'h00, so_oe}, 8'h00);
  endtask : stat_chk

  // Security read from a start address, nb bytes, then tail bits.
  task automatic otp_read(input logic [23:0] ad, input int nb,
                          input int tail);
    osr_spi_host_inst.frame_begin();
    osr_spi_host_inst.xfer(8, CMD_OTP_READ, r, oe);
    for (int j = 2; j >= 0; j--) begin
      osr_spi_host_inst.xfer(8, ad[8*j +: 8], r, oe);
    end
    for (int j = 0; j < 2; j++) begin
      osr_spi_host_inst.xfer(8, 8'($urandom), r, oe);
      check({7'h00, oe}, 8'h00);
    end
    for (int j = 0; j < nb; j++) begin
      osr_spi_host_inst.xfer(8, 8'h00, r, oe);
      check(r, mem[7'(ad[6:0] + 7'(j))]);
    end
    osr_spi_host_inst.xfer(tail, 8'h00, r, oe);
    osr_spi_host_inst.frame_end();
    check({7'h00, so_oe}, 8'h00);
  endtask : otp_read

  // Write enable, then a status write; the bench model follows the
  // lock and pin rules to predict the outcome.
  task automatic wsr(input logic w, input logic [7:0] d);
    wp_n = w;
    cmd(CMD_WR_ENABLE, 0, 8'h00);
    m_wel = 1'b1;
    stat_chk(1);
    cmd(CMD_STAT_WRITE, 1, d);
    if (!(!w && m_lock && !d[7])) begin
      if (!(m_lock && !w)) m_prot = d[2];
      m_lock = d[7];
    end
    m_wel = 1'b0;
    stat_chk(1);
    check({7'h00, array_protect}, {7'h00, m_prot});
  endtask : wsr

  // Program or erase request; refused while protected.
  task automatic op(input logic f);
    cmd(CMD_WR_ENABLE, 0, 8'h00);
    @(negedge mclk) op_req = 1'b1;
    #1 check({7'h00, op_grant}, {7'h00, !m_prot});
    @(negedge mclk) op_req = 1'b0;
    if (!m_prot) begin
      array_busy = 1'b1;
      repeat (5) @(negedge mclk);
      op_done = 1'b1;
      op_fail = f;
      array_busy = 1'b0;
      @(negedge mclk) op_done = 1'b0;
      m_fail = f;
    end
    m_wel = 1'b0;
    stat_chk(1);
  endtask : op

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    {wp_n, array_busy, op_req, op_done, op_fail, load_we} = 6'h20;
    load_addr = 7'h00;
    load_data = 8'h00;
    {m_lock, m_prot, m_fail, m_wel} = 4'h0;
    bad_count = 0;
    n_tests = 0;
    void'($urandom(51));
    repeat (12) @(negedge mclk);
    reset_n = 1'b1;
    for (i = 0; i < OTP_DEPTH; i++) begin
      @(negedge mclk) load_we = 1'b1;
      mem[i] = 8'($urandom);
      load_addr = 7'(i);
      load_data = mem[i];
    end
    @(negedge mclk) load_we = 1'b0;
    stat_chk(2);
    // Wrap from the second-last location, then random starts and cut points.
    otp_read(24'h00007E, 4, 0);
    otp_read(24'($urandom), 3, 5);
    otp_read(24'($urandom) | 24'h00007F, 2, 1);
    // A busy device still answers; a change mid byte 2 shows up in
    // the next byte 1, not in the byte already started.
    array_busy = 1'b1;
    stat_chk(1);
    osr_spi_host_inst.frame_begin();
    osr_spi_host_inst.xfer(8, CMD_STAT_READ, r, oe);
    osr_spi_host_inst.xfer(8, 8'h00, r, oe);
    osr_spi_host_inst.xfer(4, 8'h00, t, oe);
    array_busy = 1'b0;
    wp_n = 1'b0;
    osr_spi_host_inst.xfer(4, 8'h00, r, oe);
    check({t[3:0], r[3:0]}, 8'h01);
    osr_spi_host_inst.xfer(8, 8'h00, r, oe);
    check(r, exp_b1());
    osr_spi_host_inst.frame_end();
    // Lock and protect combinations, then random ones.
    wsr(1'b1, 8'hFF);
    wsr(1'b0, 8'h00);
    wsr(1'b0, 8'h80);
    wsr(1'b1, 8'h00);
    wsr(1'b0, 8'h84);
    wsr(1'b1, 8'h80);
    wsr(1'b1, 8'h00);
    for (i = 0; i < 4; i++) wsr(1'($urandom), 8'($urandom));
    wsr(1'b1, 8'h00);
    cmd(CMD_WR_ENABLE, 0, 8'h00);
    // An unknown opcode neither answers nor drops the write latch.
    cmd(8'hA5, 1, 8'h00);
    check({7'h00, oe}, 8'h00);
    m_wel = 1'b1;
    stat_chk(1);
    cmd(CMD_WR_DISABLE, 0, 8'h00);
    m_wel = 1'b0;
    stat_chk(1);
    op(1'b1);
    wsr(1'b1, 8'h04);
    op(1'b0);
    wsr(1'b1, 8'h00);
    for (i = 0; i < 3; i++) op(1'($urandom));
    // A mid-run reset must clear lock, protect, failure and latch.
    wsr(1'b1, 8'h84);
    cmd(CMD_WR_ENABLE, 0, 8'h00);
    @(negedge mclk) reset_n = 1'b0;
    repeat (12) @(negedge mclk);
    reset_n = 1'b1;
    {m_lock, m_prot, m_fail, m_wel} = 4'h0;
    stat_chk(1);
    end_of_test();
  end

  // Watchdog reckoned well beyond the expected run length.
  initial begin
    repeat (90000) @(posedge mclk);
    bad_count++;
    $display("BAD %0t: watchdog expired", $time);
    end_of_test();
  end
endmodule : test_otp_and_status_read
